// ===== rtl/fmc_flash_ctl.sv
`timescale 1ns/1ps

module fmc_flash_ctl #(
    parameter int AW = fmc_pkg::ADDR_W
) (
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire fmc_pkg::fmc_bus_req_t bus_i,
    output logic      [7:0]           rdata_o,
    input  wire fmc_pkg::fmc_pins_t   pins_i,
    input  wire logic                 link_ok_i,
    input  wire logic                 copy_done_i,
    output logic                      copy_start_o,
    output fmc_pkg::fmc_boot_t        boot_phase_o,
    output logic                      erase_busy_o,
    output logic                      flash_enabled_o,
    output logic                      expanded_mode_o,
    output logic      [7:0]           wait_ctl_o
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        fmc_pkg::fmc_pins_t pin_s1;
        fmc_pkg::fmc_pins_t pin_s2;
        logic [1:0]         cap_cnt;
        logic               cap_done;
        logic [1:0]         mode;
        logic               boot;
        logic               writer;
        logic               software_write_enable;
        logic               ev;
        logic               pv;
        logic               e;
        logic               p;
        logic               fler;
        logic               esu;
        logic               psu;
        logic [7:0]         blk_sel;
        logic [7:0]         wait_ctl;
        logic               expanded_mode_bit;
        logic [1:0]         mds;
        fmc_pkg::fmc_rsrc_t rsrc;
        logic [7:0]         rdata;
        fmc_pkg::fmc_boot_t boot_phase;
        logic               copy_start;
        logic               e_prev;
        logic               erasing;
        logic [2:0]         blk;
        logic [15:0]        eaddr;
        logic [7:0]         emask;
        logic               flash_en;
    } fmc_state_t;

    fmc_state_t st;
    fmc_state_t next_st;

    logic          mem_we;
    logic [AW-1:0] mem_waddr;
    logic [7:0]    mem_wdata;
    logic [7:0]    mem_rdata;

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic is_flash(input logic [15:0] a);
        is_flash = (a < fmc_pkg::FLASH_TOP);
    endfunction

    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        hit = (a == r);
    endfunction

    function automatic logic [7:0] first_blk_addr_lo(input logic [2:0] b);
        first_blk_addr_lo = fmc_pkg::BLK_BASE[b][7:0];
    endfunction

    // ********************************************************
    // Next-state logic
    // ********************************************************
    logic       prog_ok;
    logic       flash_regs;
    logic [7:0] one_val;
    logic [7:0] two_val;
    logic [7:0] mode_val;
    logic       one_wr;
    logic       two_wr;
    logic       blk_wr;
    logic       e_start;

    always_comb begin
        next_st = st;
        next_st.copy_start = 1'b0;

        // Pins cross from the outside world through two flops
        next_st.pin_s1 = pins_i;
        next_st.pin_s2 = st.pin_s1;

        // Mode straps are caught once the synchroniser has settled
        if (!st.cap_done) begin
            next_st.cap_cnt = st.cap_cnt + 2'h1;
            if (st.cap_cnt == fmc_pkg::CAP_DELAY) begin
                next_st.cap_done = 1'b1;
                next_st.mode     = st.pin_s2.mode_pin;
                next_st.boot     = st.pin_s2.boot_pin;
                next_st.writer   = st.pin_s2.writer_pin;
                next_st.flash_en = (st.pin_s2.mode_pin != fmc_pkg::MODE_ONE);
                next_st.expanded_mode_bit     = (st.pin_s2.mode_pin == fmc_pkg::MODE_ONE);
                next_st.mds      = st.pin_s2.mode_pin;
                if (st.pin_s2.boot_pin) begin
                    next_st.boot_phase = fmc_pkg::BOOT_CHECK;
                end
            end
        end

        // Program and erase permission
        prog_ok = st.boot || st.writer || st.pin_s2.prog_pin;

        // Flash registers visible only when selected and flash enabled
        flash_regs = st.wait_ctl[fmc_pkg::WAIT_SEL_BIT] && st.flash_en;

        // Read views
        one_val = {1'b1, st.software_write_enable, 2'b00, st.ev, st.pv, st.e, st.p};
        two_val = {st.fler, 5'b00000, st.esu, st.psu};
        mode_val = {st.expanded_mode_bit, fmc_pkg::MODE_RSVD, st.pin_s2.mode_pin};

        one_wr = bus_i.wr && flash_regs && hit(bus_i.addr, fmc_pkg::CTL_ONE_ADDR);
        two_wr = bus_i.wr && flash_regs && hit(bus_i.addr, fmc_pkg::CTL_TWO_ADDR);
        blk_wr = bus_i.wr && flash_regs && hit(bus_i.addr, fmc_pkg::BLK_SEL_ADDR);

        // ****************************************************
        // Register writes
        // ****************************************************
        if (one_wr) begin
            next_st.software_write_enable = bus_i.wdata[fmc_pkg::ONE_SWE_BIT];
            next_st.ev  = bus_i.wdata[fmc_pkg::ONE_EV_BIT] && st.software_write_enable;
            next_st.pv  = bus_i.wdata[fmc_pkg::ONE_PV_BIT] && st.software_write_enable;
            next_st.e   = bus_i.wdata[fmc_pkg::ONE_E_BIT] && st.software_write_enable && st.esu && prog_ok;
            next_st.p   = bus_i.wdata[fmc_pkg::ONE_P_BIT] && st.software_write_enable && st.psu && prog_ok;
            if (!prog_ok && (bus_i.wdata[fmc_pkg::ONE_E_BIT] ||
                             bus_i.wdata[fmc_pkg::ONE_P_BIT])) begin
                next_st.fler = 1'b1;
            end
        end
        if (two_wr && st.software_write_enable) begin
            next_st.esu = bus_i.wdata[fmc_pkg::TWO_ESU_BIT];
            next_st.psu = bus_i.wdata[fmc_pkg::TWO_PSU_BIT];
        end
        if (blk_wr && st.software_write_enable) begin
            next_st.blk_sel = bus_i.wdata;
        end
        if (bus_i.wr && hit(bus_i.addr, fmc_pkg::WAIT_CTL_ADDR)) begin
            next_st.wait_ctl = bus_i.wdata;
        end
        if (bus_i.wr && hit(bus_i.addr, fmc_pkg::MODE_CTL_ADDR) && st.boot &&
            (st.mode != fmc_pkg::MODE_ONE)) begin
            next_st.expanded_mode_bit = bus_i.wdata[fmc_pkg::MODE_EXP_BIT];
        end

        // Control two and block select cleared while writes are disabled
        if (!next_st.software_write_enable) begin
            next_st.fler    = 1'b0;
            next_st.esu     = 1'b0;
            next_st.psu     = 1'b0;
            next_st.blk_sel = fmc_pkg::BLK_SEL_RST;
        end

        // ****************************************************
        // Register reads, answered in the next cycle
        // ****************************************************
        next_st.rsrc  = fmc_pkg::RSRC_NONE;
        next_st.rdata = fmc_pkg::READ_BLANK;
        if (bus_i.rd) begin
            next_st.rsrc = fmc_pkg::RSRC_REG;
            if (is_flash(bus_i.addr) && st.flash_en) begin
                next_st.rsrc = fmc_pkg::RSRC_MEM;
            end else if (hit(bus_i.addr, fmc_pkg::CTL_ONE_ADDR) && flash_regs) begin
                next_st.rdata = one_val;
            end else if (hit(bus_i.addr, fmc_pkg::CTL_TWO_ADDR) && flash_regs) begin
                next_st.rdata = two_val;
            end else if (hit(bus_i.addr, fmc_pkg::BLK_SEL_ADDR) && flash_regs) begin
                next_st.rdata = st.blk_sel;
            end else if (hit(bus_i.addr, fmc_pkg::WAIT_CTL_ADDR)) begin
                next_st.rdata = st.wait_ctl;
            end else if (hit(bus_i.addr, fmc_pkg::MODE_CTL_ADDR)) begin
                next_st.rdata = mode_val;
                next_st.mds   = st.pin_s2.mode_pin;
            end
        end

        // ****************************************************
        // Boot sequence
        // ****************************************************
        case (st.boot_phase)
            fmc_pkg::BOOT_IDLE: begin
                next_st.boot_phase = next_st.boot_phase;
            end
            fmc_pkg::BOOT_CHECK: begin
                if (link_ok_i) begin
                    next_st.boot_phase = fmc_pkg::BOOT_COPY;
                    next_st.copy_start = 1'b1;
                end
            end
            fmc_pkg::BOOT_COPY: begin
                if (copy_done_i) begin
                    // Host routine now runs from RAM and programs the array
                    next_st.boot_phase = fmc_pkg::BOOT_RUN;
                end
            end
            fmc_pkg::BOOT_RUN: begin
                next_st.boot_phase = fmc_pkg::BOOT_RUN;
            end
            default: begin
                next_st.boot_phase = fmc_pkg::BOOT_IDLE;
            end
        endcase

        // ****************************************************
        // Erase engine
        // ****************************************************
        next_st.e_prev = st.e;
        e_start = st.e && !st.e_prev && !st.erasing && prog_ok;
        if (e_start) begin
            next_st.erasing = 1'b1;
            next_st.blk     = 3'h0;
            next_st.eaddr   = fmc_pkg::BLK_BASE[0];
            // Boot mode always wipes every block
            next_st.emask   = st.boot ? 8'hFF : st.blk_sel;
        end else if (st.erasing) begin
            if (!st.emask[st.blk] || st.eaddr == fmc_pkg::BLK_LAST[st.blk]) begin
                if (st.blk == 3'h7) begin
                    next_st.erasing = 1'b0;
                end else begin
                    next_st.blk   = st.blk + 3'h1;
                    next_st.eaddr = fmc_pkg::BLK_BASE[st.blk + 3'h1];
                end
            end else begin
                next_st.eaddr = st.eaddr + 16'h0001;
            end
        end
    end

    // ********************************************************
    // Array write port
    // ********************************************************
    always_comb begin
        mem_we    = 1'b0;
        mem_waddr = st.eaddr[AW-1:0];
        mem_wdata = fmc_pkg::ERASED_BYTE;
        if (st.erasing && st.emask[st.blk]) begin
            mem_we = 1'b1;
        end else if (bus_i.wr && is_flash(bus_i.addr) && st.flash_en && st.p &&
                     prog_ok && !st.erasing) begin
            // Software programs any flash byte, erased or not, while P is set and no erase runs
            mem_we    = 1'b1;
            mem_waddr = bus_i.addr[AW-1:0];
            mem_wdata = bus_i.wdata;
        end
    end

    fmc_byte_mem #(
        .AW (AW),
        .DW (8)
    ) u_array (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .we_i     (mem_we),
        .waddr_i  (mem_waddr),
        .wdata_i  (mem_wdata),
        .raddr_i  (bus_i.addr[AW-1:0]),
        .rdata_o  (mem_rdata)
    );

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st            <= '0;
            st.mode       <= fmc_pkg::MODE_THREE;
            st.flash_en   <= 1'b1;
            st.wait_ctl   <= fmc_pkg::WAIT_CTL_RST;
            st.blk_sel    <= fmc_pkg::BLK_SEL_RST;
            st.boot_phase <= fmc_pkg::BOOT_IDLE;
            st.rsrc       <= fmc_pkg::RSRC_NONE;
        end else begin
            st <= next_st;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign rdata_o         = (st.rsrc == fmc_pkg::RSRC_MEM) ? mem_rdata : st.rdata;
    assign copy_start_o    = st.copy_start;
    assign boot_phase_o    = st.boot_phase;
    assign erase_busy_o    = st.erasing;
    assign flash_enabled_o = st.flash_en;
    assign expanded_mode_o = st.expanded_mode_bit;
    assign wait_ctl_o      = st.wait_ctl;

endmodule // fmc_flash_ctl

// ===== rtl/fmc_pkg.sv
package fmc_pkg;

    // ********************************************************
    // Register addresses
    // ********************************************************
    localparam logic [15:0] CTL_ONE_ADDR  = 16'hFF80;
    localparam logic [15:0] CTL_TWO_ADDR  = 16'hFF81;
    localparam logic [15:0] BLK_SEL_ADDR  = 16'hFF83;
    localparam logic [15:0] WAIT_CTL_ADDR = 16'hFFC2;
    localparam logic [15:0] MODE_CTL_ADDR = 16'hFFC5;

    // ********************************************************
    // Reset values, idle read byte and erased byte
    // ********************************************************
    localparam logic [7:0] CTL_ONE_RST  = 8'h80;
    localparam logic [7:0] CTL_TWO_RST  = 8'h00;
    localparam logic [7:0] BLK_SEL_RST  = 8'h00;
    localparam logic [7:0] WAIT_CTL_RST = 8'h08;
    localparam logic [7:0] READ_BLANK   = 8'h00;
    localparam logic [7:0] ERASED_BYTE  = 8'hFF;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int ONE_FWE_BIT  = 7;
    localparam int ONE_SWE_BIT  = 6;
    localparam int ONE_EV_BIT   = 3;
    localparam int ONE_PV_BIT   = 2;
    localparam int ONE_E_BIT    = 1;
    localparam int ONE_P_BIT    = 0;
    localparam int TWO_ERR_BIT  = 7;
    localparam int TWO_ESU_BIT  = 1;
    localparam int TWO_PSU_BIT  = 0;
    localparam int WAIT_SEL_BIT = 7;
    localparam int MODE_EXP_BIT = 7;
    // Fixed reserved pattern of the mode control register, bits 6..2
    localparam logic [4:0] MODE_RSVD = 5'b11001;

    // ********************************************************
    // Operating modes on the two mode pins and strap capture delay
    // ********************************************************
    localparam logic [1:0] MODE_ONE   = 2'h1;
    localparam logic [1:0] MODE_THREE = 2'h3;
    localparam logic [1:0] CAP_DELAY  = 2'h3;

    // ********************************************************
    // Flash array layout
    // ********************************************************
    localparam int          ADDR_W    = 16;
    localparam logic [15:0] FLASH_TOP = 16'hF800;
    localparam int          NUM_BLK   = 8;
    localparam logic [15:0] BLK_BASE [NUM_BLK] = '{16'h0000, 16'h0400, 16'h0800,
        16'h0C00, 16'h1000, 16'h1800, 16'h4800, 16'h8800};
    localparam logic [15:0] BLK_LAST [NUM_BLK] = '{16'h03FF, 16'h07FF, 16'h0BFF,
        16'h0FFF, 16'h17FF, 16'h47FF, 16'h87FF, 16'hF7FF};

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        BOOT_IDLE  = 2'b00,
        BOOT_CHECK = 2'b01,
        BOOT_COPY  = 2'b11,
        BOOT_RUN   = 2'b10
    } fmc_boot_t;

    typedef enum logic [1:0] {
        RSRC_NONE = 2'b00,
        RSRC_REG  = 2'b01,
        RSRC_MEM  = 2'b11
    } fmc_rsrc_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fmc_bus_req_t;

    typedef struct packed {
        logic [1:0] mode_pin;
        logic       boot_pin;
        logic       prog_pin;
        logic       writer_pin;
    } fmc_pins_t;

endpackage

// ===== rtl/fmc_byte_mem.sv
`timescale 1ns/1ps

module fmc_byte_mem #(
    parameter int AW = 16,
    parameter int DW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          resetn_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [2**AW];

    // ********************************************************
    // Write port
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // ********************************************************
    // Registered read port
    // ********************************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule // fmc_byte_mem

// ===== test/fmc_flash_ctl_props.sv
`timescale 1ns/1ps

module fmc_flash_ctl_props (
    input wire logic                  clk_i,
    input wire logic                  resetn_i,
    input wire fmc_pkg::fmc_bus_req_t bus_i,
    input wire logic [7:0]            rdata_o,
    input wire fmc_pkg::fmc_pins_t    pins_i,
    input wire logic                  copy_start_o,
    input wire fmc_pkg::fmc_boot_t    boot_phase_o,
    input wire logic                  erase_busy_o,
    input wire logic                  flash_enabled_o,
    input wire logic                  expanded_mode_o,
    input wire logic [7:0]            wait_ctl_o
);
    // ********************************************************
    // Port relations
    // ********************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    rdata_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("read data outside the read slot");
    wait_read_a: assert property (($past(bus_i.rd) && $past(bus_i.addr) == 16'hFFC2)
        |-> rdata_o == wait_ctl_o) else $error("wait control read mismatch");
    wait_write_a: assert property ((bus_i.wr && bus_i.addr == 16'hFFC2)
        |=> wait_ctl_o == $past(bus_i.wdata)) else $error("wait control write lost");
    hidden_read_a: assert property (($past(bus_i.rd) && !$past(wait_ctl_o[7])
        && $past(bus_i.addr) inside {16'hFF80, 16'hFF81, 16'hFF83}) |-> rdata_o == 8'h00)
        else $error("flash register visible while deselected");
    disabled_read_a: assert property (($past(bus_i.rd) && !$past(flash_enabled_o)
        && $past(bus_i.addr) inside {16'hFF80, 16'hFF81, 16'hFF83}) |-> rdata_o == 8'h00)
        else $error("flash register visible while flash disabled");
    mode_rsvd_a: assert property (($past(bus_i.rd) && $past(bus_i.addr) == 16'hFFC5)
        |-> rdata_o[6:2] == 5'b11001 && rdata_o[7] == $past(expanded_mode_o))
        else $error("mode control fixed bits wrong");
    mode_pins_a: assert property (($past(bus_i.rd) && $past(bus_i.addr) == 16'hFFC5
        && $past(pins_i.mode_pin, 4) == $past(pins_i.mode_pin))
        |-> rdata_o[1:0] == $past(pins_i.mode_pin)) else $error("mode select bits wrong");
    mode1_exp_a: assert property (!flash_enabled_o |-> expanded_mode_o)
        else $error("expanded bit clear in mode one");
    exp_hold_a: assert property ((bus_i.wr && bus_i.addr == 16'hFFC5
        && boot_phase_o == fmc_pkg::BOOT_IDLE) |=> $stable(expanded_mode_o))
        else $error("expanded bit changed outside boot");
    copy_order_a: assert property (copy_start_o |-> boot_phase_o == fmc_pkg::BOOT_COPY
        && $past(boot_phase_o) == fmc_pkg::BOOT_CHECK) else $error("copy began out of order");
    run_order_a: assert property (boot_phase_o == fmc_pkg::BOOT_RUN
        |-> $past(boot_phase_o) inside {fmc_pkg::BOOT_COPY, fmc_pkg::BOOT_RUN})
        else $error("boot run entered early");
    erase_mode_a: assert property ($rose(erase_busy_o)
        |-> (pins_i.boot_pin || pins_i.prog_pin || pins_i.writer_pin))
        else $error("erase started in user mode");
endmodule // fmc_flash_ctl_props

bind fmc_flash_ctl fmc_flash_ctl_props u_props (.clk_i, .resetn_i, .bus_i, .rdata_o, .pins_i,
    .copy_start_o, .boot_phase_o, .erase_busy_o, .flash_enabled_o, .expanded_mode_o, .wait_ctl_o);

// ===== test/fmc_boot_host.sv
`timescale 1ns/1ps

module fmc_boot_host (
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    input  wire fmc_pkg::fmc_boot_t boot_phase_i,
    input  wire logic               copy_start_i,
    input  wire logic [7:0]         delay_i,
    output logic                    link_ok_o,
    output logic                    copy_done_o
);
    // ********************************************************
    // Serial host answering after a chosen delay
    // ********************************************************
    logic [7:0] cnt;
    logic       copying;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt         <= 8'h00;
            copying     <= 1'b0;
            link_ok_o   <= 1'b0;
            copy_done_o <= 1'b0;
        end else begin
            if (copy_start_i) begin
                copying <= 1'b1;
                cnt     <= 8'h00;
            end else if (boot_phase_i == fmc_pkg::BOOT_CHECK || copying) begin
                cnt <= cnt + 8'h01;
            end
            link_ok_o   <= (boot_phase_i == fmc_pkg::BOOT_CHECK) && (cnt >= delay_i);
            copy_done_o <= copying && (cnt >= delay_i);
        end
    end
endmodule // fmc_boot_host

// ===== test/fmc_flash_ctl_test.sv
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module fmc_flash_ctl_test;
    logic                  clk_i;
    logic                  resetn_i;
    fmc_pkg::fmc_bus_req_t bus;
    fmc_pkg::fmc_pins_t    pins;
    fmc_pkg::fmc_boot_t    phase;
    logic [7:0]            rdata;
    logic [7:0]            wait_ctl;
    logic [7:0]            host_dly;
    logic                  link_ok, copy_done, copy_start, busy, flash_en, expanded;
    int                    miscompares, n_checks, n_copy, n;

    fmc_flash_ctl u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata),
        .pins_i(pins), .link_ok_i(link_ok), .copy_done_i(copy_done), .copy_start_o(copy_start),
        .boot_phase_o(phase), .erase_busy_o(busy), .flash_enabled_o(flash_en),
        .expanded_mode_o(expanded), .wait_ctl_o(wait_ctl));
    fmc_boot_host u_host (.clk_i(clk_i), .resetn_i(resetn_i), .boot_phase_i(phase),
        .copy_start_i(copy_start), .delay_i(host_dly), .link_ok_o(link_ok),
        .copy_done_o(copy_done));

    // ********************************************************
    // Bus, reset and erase tasks
    // ********************************************************
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] ex);
        @(posedge clk_i);
        bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        `CHK($sformatf("read %h", a), ex, rdata)
    endtask

    task automatic do_reset(input logic [1:0] m, input logic b, input logic p,
                            input logic w = 1'b0);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        pins     <= '{mode_pin: m, boot_pin: b, prog_pin: p, writer_pin: w};
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        #1;
    endtask

    task automatic erase_len(output int cnt);
        #1;
        cnt = 0;
        while (busy !== 1'b1 && cnt < 4) begin @(posedge clk_i); #1; cnt++; end
        cnt = 0;
        while (busy === 1'b1 && cnt < 70000) begin @(posedge clk_i); #1; cnt++; end
    endtask

    task automatic erase_cmd(input logic [7:0] blk);
        wr(16'hFF80, 8'h40);
        wr(16'hFF81, 8'h02);
        wr(16'hFF83, blk);
        wr(16'hFF80, 8'h42);
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic s_regs;
        do_reset(2'h3, 1'b0, 1'b0);
        rd(16'hFFC2, 8'h08);
        rd(16'hFF80, 8'h00);
        rd(16'hFF82, 8'h00);
        wr(16'hFFC2, 8'h88);
        rd(16'hFF80, 8'h80);
        `CHK("wait_ctl", 8'h88, wait_ctl)
        rd(16'hFF81, 8'h00);
        rd(16'hFF83, 8'h00);
        wr(16'hFF81, 8'h02);
        rd(16'hFF81, 8'h00);
        wr(16'hFF80, 8'h40);
        wr(16'hFF81, 8'h02);
        rd(16'hFF81, 8'h02);
        wr(16'hFF83, 8'h01);
        rd(16'hFF83, 8'h01);
        wr(16'hFF80, 8'h00);
        rd(16'hFF81, 8'h00);
        rd(16'hFF83, 8'h00);
        wr(16'hFFC2, 8'h08);
        rd(16'hFF80, 8'h00);
        rd(16'hFFC5, 8'h67);
        wr(16'hFFC5, 8'hFF);
        rd(16'hFFC5, 8'h67);
        `CHK("expanded", 1'b0, expanded)
        pins.mode_pin <= 2'h2;
        repeat (4) @(posedge clk_i);
        rd(16'hFFC5, 8'h66);
        pins.mode_pin <= 2'h3;
    endtask

    task automatic s_mode1;
        do_reset(2'h1, 1'b0, 1'b0);
        `CHK("flash_en", 1'b0, flash_en)
        `CHK("expanded", 1'b1, expanded)
        rd(16'hFFC5, 8'hE5);
        wr(16'hFFC5, 8'h00);
        rd(16'hFFC5, 8'hE5);
        wr(16'hFFC2, 8'h80);
        wr(16'hFF80, 8'h40);
        rd(16'hFF80, 8'h00);
        rd(16'h0000, 8'h00);
    endtask

    task automatic s_boot;
        host_dly <= 8'h20;
        n_copy = 0;
        do_reset(2'h3, 1'b1, 1'b0);
        n = 0;
        while (phase !== fmc_pkg::BOOT_RUN && n < 300) begin @(posedge clk_i); #1; n++; end
        `CHK("copy starts", 1, n_copy)
        `CHK("phase", fmc_pkg::BOOT_RUN, phase)
        wr(16'hFFC5, 8'h80);
        rd(16'hFFC5, 8'hE7);
        `CHK("expanded", 1'b1, expanded)
        wr(16'hFFC5, 8'h00);
        rd(16'hFFC5, 8'h67);
        wr(16'hFFC2, 8'h80);
        erase_cmd(8'h01);
        erase_len(n);
        `CHK("boot erase long", 1'b1, n > 60000)
        wr(16'hFF80, 8'h40);
        rd(16'h0000, 8'hFF);
        rd(16'h8800, 8'hFF);
        rd(16'hF7FF, 8'hFF);
    endtask

    task automatic s_user;
        do_reset(2'h3, 1'b0, 1'b0);
        wr(16'hFFC2, 8'h80);
        erase_cmd(8'h01);
        rd(16'hFF81, 8'h82);
        `CHK("busy", 1'b0, busy)
        // Writer mode may erase; an empty block mask sweeps one cycle per block
        do_reset(2'h3, 1'b0, 1'b0, 1'b1);
        wr(16'hFFC2, 8'h80);
        erase_cmd(8'h00);
        erase_len(n);
        `CHK("writer sweep", 8, n)
        rd(16'hFF81, 8'h02);
    endtask

    task automatic s_prog;
        do_reset(2'h2, 1'b0, 1'b1);
        `CHK("flash_en", 1'b1, flash_en)
        `CHK("expanded", 1'b0, expanded)
        wr(16'hFFC2, 8'h80);
        wr(16'hFF80, 8'h40);
        wr(16'hFF81, 8'h01);
        wr(16'hFF80, 8'h41);
        // Both bytes were left erased by the boot scenario
        wr(16'h03FF, 8'hA5);
        wr(16'h0400, 8'h5A);
        rd(16'h03FF, 8'hA5);
        rd(16'h0400, 8'h5A);
        erase_cmd(8'h01);
        erase_len(n);
        `CHK("block erase", 1031, n)
        wr(16'hFF80, 8'h40);
        rd(16'h03FF, 8'hFF);
        rd(16'h0400, 8'h5A);
    endtask

    task automatic stop_test;
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ********************************************************
    // Clock, sequence and watchdog
    // ********************************************************
    always @(posedge clk_i) begin
        if (copy_start === 1'b1) begin
            n_copy++;
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        resetn_i    = 1'b0;
        bus         = '0;
        pins        = '{mode_pin: 2'h3, boot_pin: 1'b0, prog_pin: 1'b0, writer_pin: 1'b0};
        host_dly    = 8'h03;
        miscompares = 0;
        n_checks    = 0;
        n_copy      = 0;
        s_regs;
        s_mode1;
        s_boot;
        s_user;
        s_prog;
        stop_test;
    end

    initial begin
        #2000000;
        miscompares++;
        stop_test;
    end
endmodule // fmc_flash_ctl_test
